// File: timer3_pkg.sv
/*
 * Constants, register map and control-field layout for the third timer/counter.
 * Assumes sys_clk is the oscillator clock of the device at 100 MHz.
 */
package timer3_pkg;

    // ***************************************************************
    // Register map (word index on the plain register port)
    // ***************************************************************
    localparam logic [2:0] ADDR_CONTROL      = 3'h0;
    localparam logic [2:0] ADDR_CAPTURE_LOW  = 3'h1;
    localparam logic [2:0] ADDR_CAPTURE_HIGH = 3'h2;
    localparam logic [2:0] ADDR_COUNT_LOW    = 3'h3;
    localparam logic [2:0] ADDR_COUNT_HIGH   = 3'h4;

    // ***************************************************************
    // Reset values and count limit
    // ***************************************************************
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hffff;

    // ***************************************************************
    // Timing: oscillator clocks per increment
    // ***************************************************************
    localparam int          OSC_PER_MACHINE_CYCLE = 12;
    localparam int          OSC_PER_STATE_TIME    = 2;
    localparam logic [3:0]  MACHINE_LAST = 4'(OSC_PER_MACHINE_CYCLE - 1);
    localparam logic [3:0]  STATE_LAST   = 4'(OSC_PER_STATE_TIME - 1);
    localparam logic [3:0]  BIT_DIV_LAST = 4'hf;
    localparam logic [3:0]  PRESC_RESET  = 4'h0;

    // ***************************************************************
    // Interrupt identity within the device
    // ***************************************************************
    localparam logic [15:0] IRQ_VECTOR    = 16'h002b;
    localparam logic [2:0]  IRQ_PRIO_RANK = 3'h6;

    // Control register, most significant field first.
    typedef struct packed {
        logic overflow_flag;
        logic external_flag;
        logic receive_clock_select;
        logic transmit_clock_select;
        logic external_enable;
        logic run_control;
        logic counter_select;
        logic capture_reload_select;
    } control_s;

endpackage

// File: timer3_capture_reload_baud.sv
/*
 * Third 16-bit timer/counter with capture, auto-reload and baud-rate modes.
 * Assumes a synchronous CPU register port, pins synchronous to sys_clk and a
 * serial port that takes the clock pulses and bit ticks this block drives.
 */
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
// Notes on behaviour
// RULE_01: Counter select picks internal timing or external event counting in every mode.
// RULE_02: Three modes; without serial selects, capture select picks capture or reload.
// RULE_03: Capture mode sets the overflow flag on every 16-bit overflow.
// RULE_04: Capture mode with external enable copies count on capture input fall.
// RULE_05: Capture input fall sets external flag, which requests interrupts too.
// RULE_06: Auto-reload rollover sets overflow flag and loads count from capture registers.
// RULE_07: Auto-reload with external enable also reloads on capture input fall.
// RULE_08: Any serial select enters baud mode; reload on high-byte rollover, ignore select.
// RULE_09: Receive and transmit selects route this timer's overflows independently.
// RULE_10: Baud mode rollover never sets the overflow flag nor interrupts.
// RULE_11: Baud mode capture input fall sets external flag without reloading.
// RULE_12: Serial bit rate equals this timer's overflow rate divided by sixteen.
// RULE_13: Timer counts every machine cycle; in baud mode every state time.
// RULE_14: Internal baud rate is oscillator over 32 times (65536 minus capture).
// RULE_15: Run control starts and stops counting; software sets it separately.
// RULE_16: Flags are never cleared by hardware; software clears via control writes.
// RULE_17: Counter operation advances on external count input pulses.
// RULE_18: Software should stop the timer before touching counts in baud timing.
// RULE_19: Interrupt request is overflow flag OR external flag, not auto-cleared.
// RULE_20: Interrupt uses vector 002BH with lowest priority within its level.
// RULE_21: Falling edges found by comparing previous and current synchronous samples.

module timer3_capture_reload_baud (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    input  wire logic        capture_reload_input,
    input  wire logic        external_count_input,
    input  wire logic        timer1_overflow,
    output logic             rx_clock_pulse,
    output logic             tx_clock_pulse,
    output logic             rx_bit_tick,
    output logic             tx_bit_tick,
    output logic             timer_irq,
    output logic      [15:0] irq_vector,
    output logic      [2:0]  irq_priority_rank
);

    // ***************************************************************
    // State
    // ***************************************************************
    timer3_pkg::control_s control;
    logic [15:0]          count;
    logic [15:0]          capture;
    logic [3:0]           presc;
    logic [3:0]           rx_div;
    logic [3:0]           tx_div;
    logic                 cr_prev;
    logic                 ec_prev;

    // ***************************************************************
    // Decode and events
    // ***************************************************************
    logic       wr_control;
    logic       wr_count;
    logic       wr_capture;
    logic       baud_mode;
    logic       cr_fall;
    logic       ec_fall;
    logic [3:0] presc_last;
    logic       presc_done;
    logic       tick;
    logic       overflow_evt;
    logic       ext_event;
    logic       do_reload;
    logic       do_capture;

    // Register port strobes per target.
    assign wr_control = reg_write && reg_addr == timer3_pkg::ADDR_CONTROL;
    assign wr_count   = reg_write && (reg_addr == timer3_pkg::ADDR_COUNT_LOW ||
                                      reg_addr == timer3_pkg::ADDR_COUNT_HIGH);
    assign wr_capture = reg_write && (reg_addr == timer3_pkg::ADDR_CAPTURE_LOW ||
                                      reg_addr == timer3_pkg::ADDR_CAPTURE_HIGH);

    // Mode and edge events; one registered sample per pin gives edge detection.
    assign baud_mode    = control.receive_clock_select |
                          control.transmit_clock_select;                 // [RULE_08]
    assign cr_fall      = cr_prev && !capture_reload_input;              // [RULE_21]
    assign ec_fall      = ec_prev && !external_count_input;              // [RULE_21]
    assign presc_last   = baud_mode ? timer3_pkg::STATE_LAST
                                    : timer3_pkg::MACHINE_LAST;          // [RULE_13]
    assign presc_done   = presc >= presc_last;
    assign tick         = control.run_control &&
                          (control.counter_select ? ec_fall : presc_done); // [RULE_01] [RULE_15] [RULE_17]
    assign overflow_evt = tick && count == timer3_pkg::COUNT_MAX;
    assign ext_event    = control.external_enable && cr_fall;
    // Reload on rollover in reload and baud modes, and on the pin only outside baud mode.
    assign do_reload    = (overflow_evt && (baud_mode || !control.capture_reload_select)) ||
                          (ext_event && !baud_mode &&
                           !control.capture_reload_select);              // [RULE_06] [RULE_07] [RULE_11]
    assign do_capture   = ext_event && !baud_mode &&
                          control.capture_reload_select;                 // [RULE_02] [RULE_04]

    // Pin samples for edge detection.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cr_prev <= 1'b1;
            ec_prev <= 1'b1;
        end else if (clk_en) begin
            cr_prev <= capture_reload_input;
            ec_prev <= external_count_input;
        end
    end

    // Prescaler: clears at or past presc_last, or while stopped, so a rate change takes effect within one period.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            presc <= timer3_pkg::PRESC_RESET;
        end else if (clk_en) begin
            if (presc_done || !control.run_control) begin
                presc <= timer3_pkg::PRESC_RESET;
            end else begin
                presc <= presc + 4'h1;
            end
        end
    end

    // ***************************************************************
    // Counter and capture registers
    // ***************************************************************
    // A CPU write beats the count; racing a running baud timer is software's hazard.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count <= timer3_pkg::WORD_RESET;
        end else if (clk_en) begin
            if (wr_count) begin                                          // [RULE_18]
                if (reg_addr == timer3_pkg::ADDR_COUNT_LOW) begin
                    count[7:0] <= reg_wdata;
                end else begin
                    count[15:8] <= reg_wdata;
                end
            end else if (do_reload) begin
                count <= capture;                                        // [RULE_06] [RULE_08]
            end else if (tick) begin
                count <= count + 16'h0001;                               // [RULE_03]
            end
        end
    end

    // Capture registers hold the reload value or the captured count.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            capture <= timer3_pkg::WORD_RESET;
        end else if (clk_en) begin
            if (wr_capture) begin
                if (reg_addr == timer3_pkg::ADDR_CAPTURE_LOW) begin
                    capture[7:0] <= reg_wdata;
                end else begin
                    capture[15:8] <= reg_wdata;
                end
            end else if (do_capture) begin
                capture <= count;                                        // [RULE_04]
            end
        end
    end

    // Control: flags set by hardware win over a clearing write in the same cycle.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            control <= timer3_pkg::control_s'(timer3_pkg::CONTROL_RESET);
        end else if (clk_en) begin
            if (wr_control) begin
                control <= timer3_pkg::control_s'(reg_wdata);            // [RULE_16]
            end
            if (overflow_evt && !baud_mode) begin
                control.overflow_flag <= 1'b1;                           // [RULE_03] [RULE_06] [RULE_10]
            end
            if (ext_event) begin
                control.external_flag <= 1'b1;                           // [RULE_05] [RULE_11]
            end
        end
    end

    // ***************************************************************
    // Register read port
    // ***************************************************************
    // Data stand one cycle after the strobe; unmapped words read as zero.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= 8'h00;
            if (reg_read) begin
                unique case (reg_addr)
                    timer3_pkg::ADDR_CONTROL:      reg_rdata <= control;
                    timer3_pkg::ADDR_CAPTURE_LOW:  reg_rdata <= capture[7:0];
                    timer3_pkg::ADDR_CAPTURE_HIGH: reg_rdata <= capture[15:8];
                    timer3_pkg::ADDR_COUNT_LOW:    reg_rdata <= count[7:0];
                    timer3_pkg::ADDR_COUNT_HIGH:   reg_rdata <= count[15:8];
                    default:                       reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ***************************************************************
    // Serial clocks and interrupt
    // ***************************************************************
    // Each direction picks its own source, so the two rates may differ.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_clock_pulse <= 1'b0;
            tx_clock_pulse <= 1'b0;
        end else if (clk_en) begin
            rx_clock_pulse <= control.receive_clock_select ? overflow_evt
                                                           : timer1_overflow; // [RULE_09]
            tx_clock_pulse <= control.transmit_clock_select ? overflow_evt
                                                            : timer1_overflow; // [RULE_09]
        end
    end

    // Divide own overflows by sixteen into bit ticks; with internal timing at
    // state rate this gives oscillator / (32 * (65536 - capture)).
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_div      <= 4'h0;
            tx_div      <= 4'h0;
            rx_bit_tick <= 1'b0;
            tx_bit_tick <= 1'b0;
        end else if (clk_en) begin
            rx_bit_tick <= 1'b0;
            tx_bit_tick <= 1'b0;
            if (overflow_evt && control.receive_clock_select) begin
                rx_div      <= rx_div + 4'h1;                            // [RULE_12] [RULE_14]
                rx_bit_tick <= rx_div == timer3_pkg::BIT_DIV_LAST;
            end
            if (overflow_evt && control.transmit_clock_select) begin
                tx_div      <= tx_div + 4'h1;                            // [RULE_12] [RULE_14]
                tx_bit_tick <= tx_div == timer3_pkg::BIT_DIV_LAST;
            end
        end
    end

    // Request follows the flags; taking the vector clears neither.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timer_irq         <= 1'b0;
            irq_vector        <= timer3_pkg::WORD_RESET;
            irq_priority_rank <= 3'h0;
        end else if (clk_en) begin
            timer_irq         <= control.overflow_flag | control.external_flag; // [RULE_19]
            irq_vector        <= timer3_pkg::IRQ_VECTOR;                 // [RULE_20]
            irq_priority_rank <= timer3_pkg::IRQ_PRIO_RANK;              // [RULE_20]
        end
    end

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_rollover_reload;
        clk_en && overflow_evt && (baud_mode || !control.capture_reload_select) && !wr_count;
    endsequence

    a_irq_follows_flags: assert property ( // [RULE_19]
        clk_en |=> timer_irq == $past(control.overflow_flag | control.external_flag))
        else $error("interrupt request does not follow the flags");
    a_overflow_sets_flag: assert property ( // [RULE_03]
        clk_en && overflow_evt && !baud_mode |=> control.overflow_flag)
        else $error("overflow did not set the overflow flag");
    a_baud_no_flag: assert property ( // [RULE_10]
        clk_en && baud_mode && !control.overflow_flag && !wr_control
        |=> !control.overflow_flag)
        else $error("baud rollover set the overflow flag");
    a_reload_value: assert property ( // [RULE_06]
        s_rollover_reload |=> count == $past(capture))
        else $error("rollover did not reload the count");
    a_capture_copy: assert property ( // [RULE_04]
        clk_en && do_capture && !wr_capture |=> capture == $past(count))
        else $error("capture edge did not copy the count");
    a_baud_pin_no_reload: assert property ( // [RULE_11]
        clk_en && baud_mode && ext_event && !tick && !wr_count |=> $stable(count))
        else $error("pin edge reloaded the count in baud mode");
    a_ext_flag_set: assert property ( // [RULE_05]
        clk_en && ext_event |=> control.external_flag)
        else $error("pin edge did not set the external flag");
    a_stopped_holds: assert property ( // [RULE_15]
        clk_en && !control.run_control && !wr_count && !ext_event |=> $stable(count))
        else $error("count moved while stopped");
    a_flag_sticky: assert property ( // [RULE_16]
        clk_en && control.overflow_flag && !wr_control |=> control.overflow_flag)
        else $error("overflow flag cleared without a write");
    a_state_rate: assert property ( // [RULE_13]
        clk_en && tick && baud_mode && !control.counter_select |=> !tick)
        else $error("baud timing ticked on consecutive clocks");
    a_rx_routing: assert property ( // [RULE_09]
        clk_en |=> rx_clock_pulse ==
            $past(control.receive_clock_select ? overflow_evt : timer1_overflow))
        else $error("receive clock routed from the wrong source");

endmodule

// File: serial_port_model.sv
/*
 * Behavioural serial port at the far side: measures the spacing of bit ticks.
 * Assumes one-cycle bit tick pulses synchronous to sys_clk.
 */
`timescale 1ns/100ps
module serial_port_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic rx_bit_tick,
    input  wire logic tx_bit_tick,
    output int        rx_period,
    output int        tx_period
);
    int rx_age;
    int tx_age;

    // Clocks between two bit ticks; the first figure after reset is meaningless.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_age    <= 0;
            tx_age    <= 0;
            rx_period <= 0;
            tx_period <= 0;
        end else begin
            rx_age <= rx_bit_tick ? 1 : rx_age + 1;
            tx_age <= tx_bit_tick ? 1 : tx_age + 1;
            if (rx_bit_tick) rx_period <= rx_age;
            if (tx_bit_tick) tx_period <= tx_age;
        end
    end
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the third timer: registers, pins, modes, serial clocks.
 * Assumes the one-cycle register port of the design and a 100 MHz sys_clk.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
    // ****************************************
    // Signals
    // ****************************************
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        capture_reload_input = 1'b1;
    logic        external_count_input = 1'b1;
    logic        timer1_overflow = 1'b0;
    logic [7:0]  reg_rdata;
    logic        rx_clock_pulse, tx_clock_pulse, rx_bit_tick, tx_bit_tick, timer_irq;
    logic [15:0] irq_vector;
    logic [2:0]  irq_priority_rank;
    int          rx_period, tx_period;
    int          mismatches = 0;
    int          comparisons = 0;
    logic [15:0] seed = 16'h0028;
    logic [15:0] v, w, cap;
    logic [7:0]  d;
    logic [3:0]  n;

    always #5 sys_clk = ~sys_clk;

    timer3_capture_reload_baud u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .capture_reload_input(capture_reload_input),
        .external_count_input(external_count_input), .timer1_overflow(timer1_overflow),
        .rx_clock_pulse(rx_clock_pulse), .tx_clock_pulse(tx_clock_pulse),
        .rx_bit_tick(rx_bit_tick), .tx_bit_tick(tx_bit_tick), .timer_irq(timer_irq),
        .irq_vector(irq_vector), .irq_priority_rank(irq_priority_rank));

    serial_port_model u_serial (.sys_clk(sys_clk), .rst(rst), .rx_bit_tick(rx_bit_tick),
        .tx_bit_tick(tx_bit_tick), .rx_period(rx_period), .tx_period(tx_period));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Clocks per bit at the internal baud rate for a given reload value.
    function automatic int bit_period(input logic [15:0] c);
        return 32 * (65536 - int'(c));
    endfunction

    // Strobes rise and fall on separate edges, so back-to-back calls never collide.
    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= x;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] x);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(negedge sys_clk);
        x = reg_rdata;
    endtask

    task automatic wr16(input logic [2:0] a, input logic [15:0] x);
        wr(a, x[7:0]);
        wr(a + 3'h1, x[15:8]);
    endtask

    task automatic rd16(input logic [2:0] a, output logic [15:0] x);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(a, lo);
        rd(a + 3'h1, hi);
        x = {hi, lo};
    endtask

    // One falling edge on a pin, held low two clocks so the sampler sees it.
    task automatic fall(input logic pin);
        @(posedge sys_clk);
        if (pin) capture_reload_input <= 1'b0;
        else external_count_input <= 1'b0;
        repeat (2) @(posedge sys_clk);
        capture_reload_input <= 1'b1;
        external_count_input <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // The tests need under 5000 clocks; four times that means a hang.
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        print_verdict();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        wr(3'h5, 8'hff);
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), d);
            `CHK(d, 8'h00)
        end
        `CHK(irq_vector, 16'h002b)
        `CHK(irq_priority_rank, 3'h6)
        $display("test reset done");
        seed = lfsr(seed);
        v = seed;
        n = {1'b0, seed[2:0]} + 4'h1;
        wr16(3'h3, v);
        wr(3'h0, 8'h03);
        fall(1'b0);
        rd16(3'h3, w);
        `CHK(w, v)
        wr(3'h0, 8'h07);
        repeat (n) fall(1'b0);
        rd16(3'h3, w);
        `CHK(w, 16'(v + 16'(n)))
        fall(1'b1);
        rd16(3'h1, w);
        `CHK(w, 16'h0000)
        wr(3'h0, 8'h0f);
        fall(1'b1);
        rd16(3'h1, w);
        `CHK(w, 16'(v + 16'(n)))
        rd(3'h0, d);
        `CHK(d, 8'h4f)
        `CHK(timer_irq, 1'b1)
        $display("test counter capture done");
        wr(3'h0, 8'h01);
        wr16(3'h3, 16'hfffe);
        wr(3'h0, 8'h05);
        rd(3'h3, d);
        `CHK(d, 8'hfe)
        repeat (11) @(posedge sys_clk);
        rd(3'h3, d);
        `CHK(d, 8'hff)
        repeat (12) @(posedge sys_clk);
        rd(3'h0, d);
        `CHK(d, 8'h85)
        rd(3'h4, d);
        `CHK(d, 8'h00)
        repeat (40) @(posedge sys_clk);
        rd(3'h0, d);
        `CHK(d, 8'h85)
        wr(3'h0, 8'h04);
        rd(3'h0, d);
        `CHK(d, 8'h04)
        `CHK(timer_irq, 1'b0)
        $display("test timer overflow done");
        wr(3'h0, 8'h0a);
        seed = lfsr(seed);
        cap = seed;
        wr16(3'h1, cap);
        wr16(3'h3, 16'hffff);
        wr(3'h0, 8'h0e);
        fall(1'b0);
        rd16(3'h3, w);
        `CHK(w, cap)
        rd(3'h0, d);
        `CHK(d, 8'h8e)
        wr(3'h0, 8'h0e);
        wr16(3'h3, ~cap);
        fall(1'b1);
        rd16(3'h3, w);
        `CHK(w, cap)
        rd(3'h0, d);
        `CHK(d, 8'h4e)
        $display("test auto reload done");
        wr(3'h0, 8'h00);
        cap = 16'hfff0 | 16'(seed[2:0]);
        wr16(3'h1, cap);
        wr16(3'h3, cap);
        wr(3'h0, 8'h34);
        repeat (3 * bit_period(cap)) @(posedge sys_clk);
        `CHK(rx_period, bit_period(cap))
        `CHK(tx_period, bit_period(cap))
        rd(3'h0, d);
        `CHK(d, 8'h34)
        wr(3'h0, 8'h30);
        wr16(3'h3, 16'hffff);
        wr(3'h0, 8'h3f);
        fall(1'b0);
        rd16(3'h3, w);
        `CHK(w, cap)
        wr16(3'h3, ~cap);
        fall(1'b1);
        rd16(3'h3, w);
        `CHK(w, ~cap)
        rd(3'h0, d);
        `CHK(d, 8'h7f)
        // Clock enable low freezes the pin sampler, so a fall while frozen is lost.
        @(posedge sys_clk);
        clk_en <= 1'b0;
        fall(1'b0);
        clk_en <= 1'b1;
        rd16(3'h3, w);
        `CHK(w, ~cap)
        $display("test baud done");
        for (int i = 0; i < 2; i++) begin
            wr(3'h0, (i == 1) ? 8'h10 : 8'h20);
            @(posedge sys_clk);
            timer1_overflow <= 1'b1;
            @(posedge sys_clk);
            timer1_overflow <= 1'b0;
            @(negedge sys_clk);
            `CHK(rx_clock_pulse, 1'(i))
            `CHK(tx_clock_pulse, 1'(1 - i))
        end
        $display("test routing done");
        print_verdict();
    end
endmodule
